// File: frame_store_map.svh
// offsets, fields, reset values and limits of the frame store
// assumes: included by bare name from the package and the design module
`ifndef FRAME_STORE_MAP_SVH
`define FRAME_STORE_MAP_SVH

// register byte offsets
`define FS_REG_MODE 8'h00
`define FS_REG_CMD 8'h04
`define FS_REG_FPR 8'h08
`define FS_REG_STATUS 8'h0C
`define FS_REG_SIZE 8'h10
`define FS_REG_OFFS 8'h14
`define FS_REG_FMT 8'h18
`define FS_REG_BPI 8'h1C

// field positions
`define FS_MODE_MSB 2
`define FS_MODE_SESS 3
`define FS_CMD_BEGIN 0
`define FS_CMD_END 1
`define FS_CMD_FLUSH 2
`define FS_ST_RUN 16
`define FS_ST_FULL 17
`define FS_LO_MSB 15
`define FS_HI_LSB 16
`define FS_PIXB_MSB 2

// reset values
`define FS_FPR_RST 16'h0001
`define FS_WIDTH_RST 16'h0280
`define FS_HEIGHT_RST 16'h01E0
`define FS_PIXB_RST 3'h1

// limits and payload padding
`define FS_MAX_IMAGES 4096
`define FS_RUN_CAP 16'h00FF
`define FS_PAD_ADD 35'h3
`define FS_WORD_SHIFT 2

// capture mode codes
`define FS_M_PASS_UNB 3'h0
`define FS_M_PASS_FIX 3'h1
`define FS_M_PASS_ONE 3'h2
`define FS_M_REC_UNB 3'h3
`define FS_M_REC_FIX 3'h4
`define FS_M_REC_ONE 3'h5
`define FS_M_DRN_UNB 3'h6
`define FS_M_DRN_ONE 3'h7

`endif

// File: frame_store_pkg.sv
// types shared by the frame store design
// assumes: frame_store_map.svh is on the include path
`include "frame_store_map.svh"
package frame_store_pkg;
    // capture modes selectable by software
    typedef enum logic [2:0] {
        pass_unbounded = `FS_M_PASS_UNB,
        pass_fixed_count = `FS_M_PASS_FIX,
        pass_one = `FS_M_PASS_ONE,
        record_unbounded = `FS_M_REC_UNB,
        record_fixed_count = `FS_M_REC_FIX,
        record_one = `FS_M_REC_ONE,
        drain_unbounded = `FS_M_DRN_UNB,
        drain_one = `FS_M_DRN_ONE
    } capture_mode_t;
    // family of a mode
    typedef enum logic [1:0] {
        cls_plain = 2'h0,
        cls_record = 2'h1,
        cls_drain = 2'h2
    } mode_class_t;
    // run controller states, gray along idle-run-halt
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_run = 2'h1,
        st_halt = 2'h3
    } run_state_t;
endpackage

// File: frame_store_acquisition_modes.sv
// acquisition-mode controller with onboard image store, APB registers
// assumes: camera and host streams run on core_clk; one word per beat
//
// Summary of operation
// - plain unbounded forwards until end command
// - plain fixed forwards configured count, stops
// - plain one forwards one image per begin
// - recording restarts append, never clear store
// - store accepts only with space, below ceiling
// - unbounded recording stops when store full
// - unbounded drain sends oldest first, removes unless session tracking is on
// - drain ends on end command or empty
// - fixed recording stores count, at most 255
// - fixed recording stops early when store full
// - status reports images held in store
// - stored count accumulates across recording runs
// - record one stores one image per begin
// - drain one sends one image per begin
// - without session tracking, drained images leave the store
// - reset leaves the store empty
// - without session tracking, recording to plain then begin clears
// - without session tracking, drain to plain/recording then begin clears
// - payload bytes from size, offsets, pixel, chunk, pad
// - session tracking keeps drained images stored
// - flush command empties the store
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "frame_store_map.svh"

module frame_store_acquisition_modes
    import frame_store_pkg::*;
#(
    parameter int MEM_WORDS = 4096,
    parameter int MAX_IMAGES = `FS_MAX_IMAGES,
    parameter int SENSOR_W = 4096,
    parameter int SENSOR_H = 4096
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cam_valid,
    input wire logic [31:0] cam_data,
    input wire logic cam_last,
    output logic cam_ready,
    output logic host_valid,
    output logic [31:0] host_data,
    output logic host_last,
    input wire logic host_ready,
    output logic run_active
);
    // ========================================
    // sizes and elaboration checks
    localparam int AW = $clog2(MEM_WORDS);
    localparam int SW = $clog2(MAX_IMAGES);
    localparam int CW = SW + 1;

    if (MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad_mem
        $error("MEM_WORDS must be a power of two");
    end
    if (MAX_IMAGES < 2 || (MAX_IMAGES & (MAX_IMAGES - 1)) != 0) begin : g_bad_img
        $error("MAX_IMAGES must be a power of two");
    end

    // ========================================
    // functions
    // family of a capture mode
    function automatic mode_class_t cls_of(input capture_mode_t m);
        case (m)
            record_unbounded, record_fixed_count, record_one: cls_of = cls_record;
            drain_unbounded, drain_one: cls_of = cls_drain;
            default: cls_of = cls_plain;
        endcase
    endfunction

    // true for offsets that hold a register
    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `FS_REG_MODE, `FS_REG_CMD, `FS_REG_FPR, `FS_REG_STATUS,
            `FS_REG_SIZE, `FS_REG_OFFS, `FS_REG_FMT, `FS_REG_BPI: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // ========================================
    // declarations
    capture_mode_t mode_ff; // selected mode
    capture_mode_t run_mode_ff; // mode latched at begin
    mode_class_t last_cls_ff; // family of last run
    run_state_t state_ff; // run controller
    run_state_t nxt_state;
    logic session_ff; // session tracking on
    logic [15:0] fpr_ff; // frames per run
    logic [15:0] width_ff, height_ff, offx_ff, offy_ff; // image geometry
    logic [2:0] pixb_ff; // bytes per pixel
    logic [15:0] chunk_ff; // chunk bytes
    logic [31:0] bpi_ff; // payload bytes per image
    logic [31:0] wpi_ff; // payload words per image
    logic [31:0] prdata_ff; // read data captured in setup
    logic [31:0] mem [MEM_WORDS]; // image words
    logic [AW:0] len_mem [MAX_IMAGES]; // words per stored image
    logic [SW-1:0] head_ff, tail_ff, cur_ff; // image slots
    logic [AW-1:0] head_addr_ff, wr_addr_ff, rd_addr_ff; // word pointers
    logic [CW-1:0] count_ff, cur_off_ff; // images held, cursor offset
    logic [AW:0] used_ff, wlen_ff, rem_ff; // used words, frame counters
    logic [15:0] done_ff; // frames finished this run
    logic cam_mid_ff, take_ff, rd_mid_ff; // frame-in-progress flags
    logic out_v_ff, out_last_ff; // host output register
    logic [31:0] out_data_ff;

    logic acc, wr_fire, cmd_wr, begin_cmd, end_cmd, flush_cmd, clear_now;
    logic space_ok, room_left, avail, busy, done_now, take_new, take_now;
    logic cam_fire, out_free, pass_load, drn_start, drn_push, drn_end, rec_end;
    logic wr_word;
    logic [AW:0] rec_len;
    logic [31:0] rd_mux, free_words;
    mode_class_t run_cls;

    // ========================================
    // APB slave: zero wait states, frozen while ce is low
    assign acc = psel & penable;
    assign pready = ce;
    assign wr_fire = acc & pwrite & ce;
    assign pslverr = acc & ~addr_ok(paddr);
    assign prdata = prdata_ff;
    assign cmd_wr = wr_fire & (paddr == `FS_REG_CMD);
    assign begin_cmd = cmd_wr & pwdata[`FS_CMD_BEGIN];
    assign end_cmd = cmd_wr & pwdata[`FS_CMD_END];
    assign flush_cmd = cmd_wr & pwdata[`FS_CMD_FLUSH];

    // read multiplexer, sampled in the setup phase
    always_comb begin
        rd_mux = '0;
        case (paddr)
            `FS_REG_MODE: rd_mux = {28'h0, session_ff, mode_ff};
            `FS_REG_FPR: rd_mux = {16'h0, fpr_ff};
            `FS_REG_STATUS: begin
                rd_mux[CW-1:0] = count_ff;
                rd_mux[`FS_ST_RUN] = (state_ff != st_idle);
                rd_mux[`FS_ST_FULL] = ~space_ok;
            end
            `FS_REG_SIZE: rd_mux = {height_ff, width_ff};
            `FS_REG_OFFS: rd_mux = {offy_ff, offx_ff};
            `FS_REG_FMT: rd_mux = {chunk_ff, 13'h0, pixb_ff};
            `FS_REG_BPI: rd_mux = bpi_ff;
            default: rd_mux = '0;
        endcase
    end

    // read data register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_ff <= '0;
        end else if (ce && psel && !penable) begin
            prdata_ff <= rd_mux;
        end
    end

    // software-written configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_ff <= pass_unbounded;
            session_ff <= 1'b0;
            fpr_ff <= `FS_FPR_RST;
            width_ff <= `FS_WIDTH_RST;
            height_ff <= `FS_HEIGHT_RST;
            offx_ff <= '0;
            offy_ff <= '0;
            pixb_ff <= `FS_PIXB_RST;
            chunk_ff <= '0;
        end else if (wr_fire) begin
            case (paddr)
                `FS_REG_MODE: begin
                    mode_ff <= capture_mode_t'(pwdata[`FS_MODE_MSB:0]);
                    session_ff <= pwdata[`FS_MODE_SESS];
                end
                `FS_REG_FPR: fpr_ff <= pwdata[`FS_LO_MSB:0];
                `FS_REG_SIZE: begin
                    width_ff <= pwdata[`FS_LO_MSB:0];
                    height_ff <= pwdata[31:`FS_HI_LSB];
                end
                `FS_REG_OFFS: begin
                    offx_ff <= pwdata[`FS_LO_MSB:0];
                    offy_ff <= pwdata[31:`FS_HI_LSB];
                end
                `FS_REG_FMT: begin
                    pixb_ff <= pwdata[`FS_PIXB_MSB:0];
                    chunk_ff <= pwdata[31:`FS_HI_LSB];
                end
                default: ; // command, read-only or unmapped: no configuration change
            endcase
        end
    end

    // ========================================
    // payload size: window clipped by sensor, padded to whole words
    always_ff @(posedge core_clk or posedge rst) begin
        logic [31:0] ew, eh, wds;
        logic [34:0] raw;
        if (rst) begin
            bpi_ff <= '0;
            wpi_ff <= 32'h1;
        end else if (ce) begin
            ew = (32'(offx_ff) >= 32'(SENSOR_W)) ? 32'h0 :
                 (32'(width_ff) < 32'(SENSOR_W) - 32'(offx_ff)) ? 32'(width_ff) :
                 32'(SENSOR_W) - 32'(offx_ff);
            eh = (32'(offy_ff) >= 32'(SENSOR_H)) ? 32'h0 :
                 (32'(height_ff) < 32'(SENSOR_H) - 32'(offy_ff)) ? 32'(height_ff) :
                 32'(SENSOR_H) - 32'(offy_ff);
            raw = 35'(ew) * 35'(eh) * 35'(pixb_ff) + 35'(chunk_ff) + `FS_PAD_ADD;
            bpi_ff <= {raw[31:`FS_WORD_SHIFT], 2'b00};
            wds = 32'(raw[34:`FS_WORD_SHIFT]);
            wpi_ff <= (wds == 32'h0) ? 32'h1 : wds;
        end
    end

    // ========================================
    // run control
    assign run_cls = cls_of(run_mode_ff);
    assign free_words = 32'(MEM_WORDS) - 32'(used_ff);
    assign space_ok = (32'(count_ff) < 32'(MAX_IMAGES)) && (free_words >= wpi_ff);
    assign avail = (cur_off_ff < count_ff);
    assign busy = (cam_mid_ff & take_ff) | rd_mid_ff;

    // frames still allowed in this run
    always_comb begin
        case (run_mode_ff)
            pass_fixed_count: room_left = (done_ff < fpr_ff);
            record_fixed_count: room_left = (done_ff < fpr_ff) && (done_ff < `FS_RUN_CAP);
            pass_one, record_one, drain_one: room_left = (done_ff == 16'h0);
            default: room_left = 1'b1;
        endcase
    end

    // run ends at a frame boundary once nothing more may pass
    assign done_now = ~busy & (~room_left |
        ((run_cls == cls_record) & ~space_ok) |
        ((run_cls == cls_drain) & ~avail));

    // clear on begin after recording when plain is selected, or after drain when drain is not, unless sessions are tracked
    assign clear_now = begin_cmd & (state_ff == st_idle) & ~session_ff &
        (((last_cls_ff == cls_record) & (cls_of(mode_ff) == cls_plain)) |
         ((last_cls_ff == cls_drain) & (cls_of(mode_ff) != cls_drain)));

    // next run state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_idle: if (begin_cmd) nxt_state = st_run;
            st_run: begin
                if (end_cmd) nxt_state = st_halt;
                else if (done_now) nxt_state = st_idle;
            end
            st_halt: if (!busy) nxt_state = st_idle;
            default: nxt_state = st_idle;
        endcase
    end

    // state, latched mode and family of the last run
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= st_idle;
            run_mode_ff <= pass_unbounded;
            last_cls_ff <= cls_plain;
        end else if (ce) begin
            state_ff <= nxt_state;
            if (begin_cmd && state_ff == st_idle) begin
                run_mode_ff <= mode_ff;
                last_cls_ff <= cls_of(mode_ff);
            end
        end
    end
    assign run_active = (state_ff != st_idle);

    // frames finished in this run
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_ff <= '0;
        end else if (ce) begin
            if (begin_cmd && state_ff == st_idle) done_ff <= '0;
            else if ((pass_load && cam_last) || rec_end || drn_end) done_ff <= done_ff + 16'h1;
        end
    end

    // ========================================
    // camera side: frames not taken are drained and dropped
    assign take_new = (state_ff == st_run) & room_left & (run_cls != cls_drain) &
                      ((run_cls == cls_plain) | space_ok);
    assign take_now = cam_mid_ff ? take_ff : take_new;
    assign out_free = ~out_v_ff | host_ready;
    assign cam_ready = (take_now && run_cls == cls_plain) ? out_free : 1'b1;
    assign cam_fire = cam_valid & cam_ready;
    assign pass_load = cam_fire & take_now & (run_cls == cls_plain);
    assign wr_word = cam_fire & take_now & (run_cls == cls_record) &
                     (32'(wlen_ff) < wpi_ff);
    assign rec_end = cam_fire & take_now & (run_cls == cls_record) & cam_last;
    assign rec_len = wr_word ? wlen_ff + 1'b1 : wlen_ff;

    // frame position of the camera stream
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cam_mid_ff <= 1'b0;
            take_ff <= 1'b0;
        end else if (ce) begin
            if (clear_now || flush_cmd) take_ff <= 1'b0;
            else if (cam_fire && !cam_mid_ff) take_ff <= take_new;
            if (cam_fire) cam_mid_ff <= ~cam_last;
        end
    end

    // image words written to memory, excess beyond payload dropped
    always_ff @(posedge core_clk) begin
        if (ce && wr_word) mem[wr_addr_ff] <= cam_data;
        if (ce && rec_end) len_mem[tail_ff] <= rec_len;
    end

    // ========================================
    // drain side: oldest image first, one word per free output slot
    assign drn_start = (state_ff == st_run) & room_left & (run_cls == cls_drain) &
                       ~rd_mid_ff & avail;
    assign drn_push = rd_mid_ff & out_free;
    assign drn_end = drn_push & (rem_ff == {{AW{1'b0}}, 1'b1});

    // drain cursor and remaining words of the current image
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_mid_ff <= 1'b0;
            rem_ff <= '0;
            cur_ff <= '0;
            cur_off_ff <= '0;
            rd_addr_ff <= '0;
        end else if (ce) begin
            if (clear_now || flush_cmd) begin
                rd_mid_ff <= 1'b0;
                cur_ff <= '0;
                cur_off_ff <= '0;
                rd_addr_ff <= '0;
            end else if (begin_cmd && state_ff == st_idle) begin
                cur_ff <= head_ff;
                cur_off_ff <= '0;
                rd_addr_ff <= head_addr_ff;
            end else if (drn_start) begin
                rd_mid_ff <= 1'b1;
                rem_ff <= len_mem[cur_ff];
            end else if (drn_push) begin
                rd_addr_ff <= rd_addr_ff + 1'b1;
                rem_ff <= rem_ff - 1'b1;
                if (drn_end) begin
                    rd_mid_ff <= 1'b0;
                    cur_ff <= cur_ff + 1'b1;
                    if (session_ff) cur_off_ff <= cur_off_ff + 1'b1;
                end
            end
        end
    end

    // ========================================
    // store bookkeeping: empty at reset, flush and begin with clear_now
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            head_ff <= '0;
            tail_ff <= '0;
            count_ff <= '0;
            used_ff <= '0;
            head_addr_ff <= '0;
            wr_addr_ff <= '0;
            wlen_ff <= '0;
        end else if (ce) begin
            if (flush_cmd || clear_now) begin
                head_ff <= '0;
                tail_ff <= '0;
                count_ff <= '0;
                used_ff <= '0;
                head_addr_ff <= '0;
                wr_addr_ff <= '0;
                wlen_ff <= '0;
            end else if (rec_end) begin
                tail_ff <= tail_ff + 1'b1;
                count_ff <= count_ff + 1'b1;
                used_ff <= used_ff + rec_len;
                wr_addr_ff <= wr_word ? wr_addr_ff + 1'b1 : wr_addr_ff;
                wlen_ff <= '0;
            end else if (wr_word) begin
                wr_addr_ff <= wr_addr_ff + 1'b1;
                wlen_ff <= wlen_ff + 1'b1;
            end else if (drn_end && !session_ff) begin
                head_ff <= head_ff + 1'b1;
                count_ff <= count_ff - 1'b1;
                used_ff <= used_ff - len_mem[head_ff];
                head_addr_ff <= rd_addr_ff + 1'b1;
            end
        end
    end

    // ========================================
    // host output register, fed by pass-through or drain
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_v_ff <= 1'b0;
            out_last_ff <= 1'b0;
            out_data_ff <= '0;
        end else if (ce) begin
            if (pass_load) begin
                out_v_ff <= 1'b1;
                out_data_ff <= cam_data;
                out_last_ff <= cam_last;
            end else if (drn_push) begin
                out_v_ff <= 1'b1;
                out_data_ff <= mem[rd_addr_ff];
                out_last_ff <= drn_end;
            end else if (host_ready) begin
                out_v_ff <= 1'b0;
            end
        end
    end
    assign host_valid = out_v_ff;
    assign host_data = out_data_ff;
    assign host_last = out_last_ff;

endmodule // frame_store_acquisition_modes
`default_nettype wire

// File: frame_store_acquisition_modes_properties.sv
// port checker of the frame store controller
// assumes: bound into the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "frame_store_map.svh"
// ========================================
// checker
module fs_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic cam_ready,
    input wire logic host_valid,
    input wire logic [31:0] host_data,
    input wire logic host_ready,
    input wire logic run_active
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // command write taken in the access phase
    wire logic cmd_wr = psel && penable && ce && pwrite && paddr == `FS_REG_CMD;
    AST_HOLD: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
        else $error("host word not held");
    AST_RST: assert property ($fell(rst) |-> !run_active && !host_valid)
        else $error("state not empty after reset");
    AST_BEGIN: assert property (cmd_wr && pwdata[0] && !run_active |=> run_active)
        else $error("begin did not start a run");
    AST_END: assert property (cmd_wr && pwdata[1] && !pwdata[0] && !run_active |=> !run_active)
        else $error("end started a run");
    AST_IDLE: assert property ((!run_active && !host_valid) ##1 !run_active |-> !host_valid)
        else $error("host word outside a run");
    AST_DROP: assert property (!run_active |-> cam_ready)
        else $error("camera stalled while idle");
    AST_FREEZE: assert property (!ce |=> $stable(run_active) && $stable(host_valid))
        else $error("state moved while disabled");
    AST_ERR: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
        else $error("unmapped access not refused");
    AST_OK: assert property (psel && penable && paddr == `FS_REG_STATUS |-> !pslverr)
        else $error("status access refused");
    cover property (cmd_wr && pwdata[0]);
    cover property (host_valid && host_ready);
    cover property (psel && penable && pslverr);
endmodule // fs_checker
bind frame_store_acquisition_modes fs_checker chk_inst (.*);
`default_nettype wire

// File: frame_link_partner.sv
// camera source and host receiver around the frame store
// assumes: shares the store clock, frames started by bench task calls
`timescale 1ns/1ps
`default_nettype none
// ========================================
// partner model
module frame_link_partner (
    input wire logic clk,
    input wire logic slow,
    input wire logic cam_ready,
    input wire logic host_valid,
    input wire logic [31:0] host_data,
    output var logic cam_valid,
    output var logic [31:0] cam_data,
    output var logic cam_last,
    output var logic host_ready
);
    logic [31:0] rx[$]; // words taken by the host
    initial begin
        cam_valid = 1'b0;
        cam_data = '0;
        cam_last = 1'b0;
        host_ready = 1'b0;
    end
    // host side: stalls alternate cycles when slow
    always @(posedge clk) begin
        host_ready <= slow ? ~host_ready : 1'b1;
        if (host_valid && host_ready) begin
            rx.push_back(host_data);
        end
    end
    // camera side: each word held until taken
    task automatic send(input logic [31:0] q[$]);
        for (int i = 0; i < q.size(); i++) begin
            cam_valid <= 1'b1;
            cam_data <= q[i];
            cam_last <= (i == q.size() - 1);
            do @(posedge clk); while (cam_ready !== 1'b1);
        end
        cam_valid <= 1'b0;
        cam_last <= 1'b0;
        cam_data <= ~q[q.size() - 1];
    endtask
endmodule // frame_link_partner
`default_nettype wire

// File: frame_store_acquisition_modes_tb.sv
// self-checking bench of the frame store controller
// assumes: checker and partner model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "frame_store_map.svh"
// ========================================
// bench top
module frame_store_acquisition_modes_tb
    import frame_store_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd_v, seed = 32'h00013884;
    logic [31:0] prdata, cam_data, host_data, st[$], pq[$];
    logic pready, pslverr, cam_valid, cam_last, cam_ready, host_valid, host_last, host_ready;
    logic run_active, err;
    int n_mismatch = 0, cmp_count = 0;
    always #25 core_clk = ~core_clk;
    frame_store_acquisition_modes #(.MEM_WORDS(64), .MAX_IMAGES(16))
        frame_store_acquisition_modes_inst (.*);
    frame_link_partner frame_link_partner_inst (.clk(core_clk), .*);
    // ========================================
    // expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // payload bytes rounded up to whole words
    function automatic logic [31:0] pay(input int w, h, pb, ch);
        return 32'((w * h * pb + ch + 3) / 4 * 4);
    endfunction
    task automatic chk(input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one apb transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cnt(input int n);
        apb(1'b0, `FS_REG_STATUS, 32'h0);
        chk(rd_v & 32'h1FFF, n);
    endtask
    // select a mode, then begin
    task automatic run(input logic [3:0] m);
        apb(1'b1, `FS_REG_MODE, 32'(m));
        apb(1'b1, `FS_REG_CMD, 32'h1);
    endtask
    // bounded wait for the run to finish
    task automatic idle();
        int k = 0;
        @(posedge core_clk);
        while (run_active !== 1'b0 && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        repeat (20) @(posedge core_clk);
    endtask
    // two random words; kind 1 expected stored, 2 expected passed
    task automatic frame(input int kind);
        logic [31:0] q[$];
        repeat (2) begin
            seed = lfsr(seed);
            q.push_back(seed);
        end
        if (kind == 1) st = {st, q};
        if (kind == 2) pq = {pq, q};
        frame_link_partner_inst.send(q);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic rxchk(input logic [31:0] ex[$]);
        chk(32'(frame_link_partner_inst.rx.size()), 32'(ex.size()));
        foreach (ex[i]) chk(frame_link_partner_inst.rx[i], ex[i]);
        frame_link_partner_inst.rx = {};
    endtask
    // ========================================
    // scenarios
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        cnt(0);
        apb(1'b0, `FS_REG_BPI, 32'h0);
        chk(rd_v, pay(640, 480, 1, 0));
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, `FS_REG_SIZE, 32'h00010008);
        apb(1'b0, `FS_REG_BPI, 32'h0);
        chk(rd_v, pay(8, 1, 1, 0));
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
        $display("done: reset and map");
        run({1'b0, pass_one});
        frame(2);
        frame(0);
        rxchk(pq);
        pq = {};
        run({1'b0, pass_unbounded});
        repeat (3) frame(2);
        chk(32'(run_active), 32'h1);
        apb(1'b1, `FS_REG_CMD, 32'h2);
        idle();
        rxchk(pq);
        pq = {};
        apb(1'b1, `FS_REG_FPR, 32'h3);
        run({1'b0, pass_fixed_count});
        repeat (3) frame(2);
        frame(0);
        rxchk(pq);
        pq = {};
        $display("done: plain modes");
        repeat (2) begin
            run({1'b0, record_fixed_count});
            repeat (3) frame(1);
            idle();
            cnt(st.size() / 2);
        end
        run({1'b0, record_unbounded});
        repeat (12) frame(st.size() < 32);
        cnt(16);
        apb(1'b1, `FS_REG_CMD, 32'h2);
        idle();
        $display("done: recording");
        run({1'b0, drain_one});
        idle();
        rxchk(st[0:1]);
        st = st[2:$];
        cnt(15);
        slow <= 1'b1;
        run({1'b0, drain_unbounded});
        idle();
        rxchk(st);
        st = {};
        cnt(0);
        slow <= 1'b0;
        $display("done: readout");
        run({1'b0, record_one});
        frame(1);
        cnt(1);
        run({1'b0, pass_unbounded});
        st = {};
        cnt(0);
        apb(1'b1, `FS_REG_CMD, 32'h2);
        idle();
        repeat (2) begin
            run({1'b0, record_one});
            frame(1);
        end
        run({1'b0, drain_one});
        idle();
        rxchk(st[0:1]);
        st = st[2:$];
        run({1'b0, record_one});
        st = {};
        cnt(0);
        frame(1);
        run({1'b1, drain_one});
        idle();
        rxchk(st);
        cnt(1);
        apb(1'b1, `FS_REG_CMD, 32'h4);
        st = {};
        cnt(0);
        $display("done: clearing");
        test_done();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        test_done();
    end
endmodule // frame_store_acquisition_modes_tb
`default_nettype wire
